// ==== rtl/efps_pkg.sv ====
// package of constants for the external flash port sequencer
package efps_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 24;
  // register offsets on the plain register port
  localparam logic [3:0] OFS_FLASH_SEL = 4'h0;
  localparam logic [3:0] OFS_BANK_SEL = 4'h1;
  localparam logic [3:0] OFS_SPARE_TWO = 4'h2;
  localparam logic [3:0] OFS_SPARE_THREE = 4'h3;
  localparam logic [3:0] OFS_BUS_WAIT = 4'h4;
  localparam logic [3:0] OFS_OP_MODE = 4'h5;
  localparam logic [3:0] OFS_CMD = 4'h6;
  localparam logic [3:0] OFS_TADDR = 4'h7;
  localparam logic [3:0] OFS_TDATA = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'h9;
  localparam logic [3:0] OFS_RDATA = 4'hA;
  // attribute register fields
  localparam int AT_TYPE_LSB = 0;
  localparam logic [1:0] AT_TYPE_ASYNC = 2'h1;
  localparam int AT_POL_BIT = 2;
  localparam int AT_P_BIT = 3;
  localparam int AT_X_BIT = 4;
  localparam int AT_Y_BIT = 5;
  localparam int AT_SWAP_BIT = 6;
  localparam int AT_PACK_BIT = 7;
  localparam int AT_NCMP_LSB = 8;
  localparam int AT_REF_LSB = 12;
  // bus wait field positions
  localparam int BW_A0_LSB = 0;
  localparam int BW_A1_LSB = 5;
  localparam int BW_A2_LSB = 10;
  localparam int BW_A3_LSB = 13;
  localparam int BW_DEF_LSB = 16;
  // operating mode bits
  localparam int OM_BUS_OFF_BIT = 4;
  localparam int OM_TA_SYNC_BIT = 11;
  localparam int OM_REL_BIT = 12;
  localparam int OM_PRIO_DIS_BIT = 14;
  // reset values of the configuration registers
  localparam logic [23:0] RST_FLASH_SEL = 24'h100731;
  localparam logic [23:0] RST_BANK_SEL = 24'h100715;
  localparam logic [23:0] RST_SPARE = 24'h000000;
  localparam logic [23:0] RST_BUS_WAIT = 24'h00018C;
  localparam logic [23:0] RST_OP_MODE = 24'h004000;
  // flash command words and addresses, relative to the flash base
  localparam logic [23:0] CMD_UNLOCK1 = 24'hAAAA00;
  localparam logic [23:0] CMD_UNLOCK2 = 24'h555500;
  localparam logic [23:0] CMD_PROGRAM = 24'hA0A000;
  localparam logic [23:0] CMD_ERASE_SETUP = 24'h808000;
  localparam logic [23:0] CMD_SECTOR_ERASE = 24'h303000;
  localparam logic [23:0] FL_BASE = 24'h100000;
  localparam logic [23:0] FL_ADR_5555 = 24'h005555;
  localparam logic [23:0] FL_ADR_2AAA = 24'h002AAA;
  localparam logic [15:0] ERASED_HI = 16'hFFFF;
  // timing: 80 MHz core with a 150 ns part needs twelve waits
  localparam int CORE_MHZ = 80;
  localparam int FLASH_ACC_NS = 150;
  localparam int FLASH_WAITS = (FLASH_ACC_NS * CORE_MHZ + 999) / 1000;
  // command codes of the sequencer
  localparam logic [1:0] OP_NONE = 2'h0;
  localparam logic [1:0] OP_PROGRAM = 2'h1;
  localparam logic [1:0] OP_ERASE = 2'h2;
  localparam logic [1:0] OP_READ = 2'h3;
  // memory space of an external access
  localparam logic [1:0] SP_P = 2'h0;
  localparam logic [1:0] SP_X = 2'h1;
  localparam logic [1:0] SP_Y = 2'h2;
  typedef enum logic [2:0] {
    EFPS_IDLE = 3'b000,
    EFPS_ISSUE = 3'b001,
    EFPS_WAIT = 3'b011,
    EFPS_POLL = 3'b010,
    EFPS_DONE = 3'b110
  } efps_state_t;
endpackage : efps_pkg

// ==== rtl/efps_attr_decode.sv ====
// one address-attribute line decoder
`timescale 1ns/10ps
module efps_attr_decode
  import efps_pkg::*;
#(
  parameter int AW = 24
) (
  input wire logic [23:0] cfg,
  input wire logic [AW-1:0] addr,
  input wire logic [1:0] space,
  input wire logic active,
  output logic hit
);
  logic [11:0] ref_hi;
  logic [11:0] adr_hi;
  logic [11:0] cmp_mask;
  logic [3:0] ncmp;
  logic space_ok;
  logic type_ok;
  assign ref_hi = cfg[AT_REF_LSB +: 12];
  assign adr_hi = addr[AW-1 -: 12];
  assign ncmp = cfg[AT_NCMP_LSB +: 4];
  // (R15) top ncmp bits compared
  assign cmp_mask = ~(12'hFFF >> ncmp);
  // (R13) space enables P, X, Y
  assign space_ok = (space == SP_P && cfg[AT_P_BIT]) ||
                    (space == SP_X && cfg[AT_X_BIT]) ||
                    (space == SP_Y && cfg[AT_Y_BIT]);
  // (R11) zero type keeps a line quiet
  assign type_ok = cfg[AT_TYPE_LSB +: 2] == AT_TYPE_ASYNC;
  assign hit = active && type_ok && space_ok && (ncmp != 4'h0) &&
               (((adr_hi ^ ref_hi) & cmp_mask) == 12'h000);
endmodule : efps_attr_decode

// ==== rtl/efps_wait_timer.sv ====
// wait-state counter for one external cycle
`timescale 1ns/10ps
module efps_wait_timer #(
  parameter int CW = 5
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [CW-1:0] waits,
  output logic busy,
  output logic last
);
  logic [CW-1:0] cnt_ff;
  logic busy_ff;
  assign busy = busy_ff;
  assign last = busy_ff && (cnt_ff == '0);
  // loads on start, counts down to zero, then one more ending cycle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= '0;
      busy_ff <= 1'b0;
    end else if (start) begin
      cnt_ff <= waits;
      busy_ff <= 1'b1;
    end else if (busy_ff) begin
      if (cnt_ff == '0) begin
        busy_ff <= 1'b0;
      end else begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule : efps_wait_timer

// ==== rtl/efps_sequencer.sv ====
// external flash port sequencer: registers, command walker, port cycles
//
// Notes on behaviour
// (R1) twelve wait states on flash accesses
// (R2) select line asserts in 100000-11FFFF, X or Y
// (R3) bank line picks X or Y flash half
// (R4) program only erased words (software's duty)
// (R5) erase acts on whole 64K-byte sector
// (R6) program: three unlock writes then data
// (R7) poll target until read equals data
// (R8) erase: six writes, last to sector
// (R9) poll sector until upper bits all ones
// (R10) only upper sixteen data bits matter
// (R11) type field 1 gives async cycles
// (R12) bit 2 sets line polarity
// (R13) bits 3-5 enable P, X, Y spaces
// (R14) swap and packing bits stay cleared
// (R15) compare count and reference high address
// (R16) per-area wait counts in bus control
// (R17) default wait and hold bits zero
// (R18) priority disable lets lines overlap
// (R19) bus-off bit stops external cycles
// (R20) release and acknowledge bits held zero
// (R21) spare attribute registers stay zero
// (R22) hold address, selects, strobe for waits
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module efps_sequencer
  import efps_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [3:0] reg_addr,
  input wire logic [23:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [23:0] reg_rdata,
  output logic [23:0] ext_addr,
  output logic [23:0] ext_dout,
  output logic ext_doe,
  input wire logic [23:0] ext_din,
  output logic ext_rd_b,
  output logic ext_wr_b,
  output logic flash_select_line,
  output logic bank_select_line,
  output logic seq_busy
);
  import efps_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // configuration registers
  logic [23:0] flash_select_attr_cfg_ff;
  logic [23:0] bank_select_attr_cfg_ff;
  logic [23:0] bus_wait_control_ff;
  logic [23:0] operating_mode_cfg_ff;
  logic [23:0] taddr_ff;
  logic [15:0] tdata_ff;
  logic [1:0] tspace_ff;
  logic [15:0] rd_word_ff;
  logic done_ff;
  logic cmd_go;
  logic [1:0] cmd_op;

  // state sits up here because the write decode already reads it
  efps_state_t state_ff;
  logic seq_busy_ff;
  logic polling_ff;


  // writable masks keep reserved and fixed bits at zero
  // (R14) swap and packing bits never set
  localparam logic [23:0] ATTR_WMASK = 24'hFFFF3F;
  // (R17) default wait, status and hold bits held zero
  localparam logic [23:0] BW_WMASK = 24'h00FFFF;
  // (R20) release and acknowledge bits held zero
  localparam logic [23:0] OM_WMASK = 24'h004010;

  // a command write while busy is ignored
  assign cmd_go = reg_wr && (reg_addr == OFS_CMD) && (state_ff == EFPS_IDLE);
  assign cmd_op = reg_wdata[1:0];

  // register writes; spare attribute registers are not writable
  // (R21) spare lines never assert
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      flash_select_attr_cfg_ff <= RST_FLASH_SEL;
      bank_select_attr_cfg_ff <= RST_BANK_SEL;
      bus_wait_control_ff <= RST_BUS_WAIT;
      operating_mode_cfg_ff <= RST_OP_MODE;
      taddr_ff <= 24'h000000;
      tdata_ff <= 16'h0000;
      tspace_ff <= SP_X;
    end else if (reg_wr) begin
      unique case (reg_addr)
        OFS_FLASH_SEL: flash_select_attr_cfg_ff <= reg_wdata & ATTR_WMASK;
        OFS_BANK_SEL: bank_select_attr_cfg_ff <= reg_wdata & ATTR_WMASK;
        OFS_BUS_WAIT: bus_wait_control_ff <= reg_wdata & BW_WMASK;
        OFS_OP_MODE: operating_mode_cfg_ff <= reg_wdata & OM_WMASK;
        OFS_TADDR: taddr_ff <= reg_wdata;
        // (R10) data lives in the upper sixteen bits
        OFS_TDATA: tdata_ff <= reg_wdata[23:8];
        OFS_CMD: begin
          if (state_ff == EFPS_IDLE) begin
            tspace_ff <= reg_wdata[3:2];
          end
        end
        default: begin
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // read port: data one cycle after the read strobe
  logic [23:0] rd_mux;
  logic [23:0] status_word;

  // status: bit 0 busy, bit 1 done, bits 3:2 space of the command
  assign status_word = {19'h0, tspace_ff, done_ff, seq_busy_ff, 1'b0} >> 1;

  assign rd_mux = (reg_addr == OFS_FLASH_SEL) ? flash_select_attr_cfg_ff :
                  (reg_addr == OFS_BANK_SEL) ? bank_select_attr_cfg_ff :
                  (reg_addr == OFS_SPARE_TWO) ? RST_SPARE :
                  (reg_addr == OFS_SPARE_THREE) ? RST_SPARE :
                  (reg_addr == OFS_BUS_WAIT) ? bus_wait_control_ff :
                  (reg_addr == OFS_OP_MODE) ? operating_mode_cfg_ff :
                  (reg_addr == OFS_TADDR) ? taddr_ff :
                  (reg_addr == OFS_TDATA) ? {tdata_ff, 8'h00} :
                  (reg_addr == OFS_STATUS) ? status_word :
                  (reg_addr == OFS_RDATA) ? {rd_word_ff, 8'h00} :
                  24'h000000;

  // read data stands one cycle, zero otherwise
  logic [23:0] reg_rdata_ff;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_ff <= 24'h000000;
    end else begin
      reg_rdata_ff <= reg_rd ? rd_mux : 24'h000000;
    end
  end
  assign reg_rdata = reg_rdata_ff;

  //////////////////////////////////////////////////////////////////////

  // command step table
  efps_state_t nxt_state;
  logic [1:0] op_ff;
  logic [2:0] step_ff;
  logic [2:0] last_step;
  logic [23:0] step_addr;
  logic [23:0] step_data;
  logic step_is_read;


  // (R6) program: unlock, unlock, program, then data word
  // (R8) erase: unlock pair, setup, unlock pair, sector word
  function automatic logic [47:0] step_word(input logic [1:0] op,
                                            input logic [2:0] st,
                                            input logic [23:0] ta,
                                            input logic [15:0] td);
    logic [47:0] w;
    w = {ta, td, 8'h00};
    if (st == 3'd0 || (op == OP_ERASE && st == 3'd3)) begin
      w = {FL_BASE + FL_ADR_5555, CMD_UNLOCK1};
    end else if (st == 3'd1 || (op == OP_ERASE && st == 3'd4)) begin
      w = {FL_BASE + FL_ADR_2AAA, CMD_UNLOCK2};
    end else if (st == 3'd2) begin
      w = {FL_BASE + FL_ADR_5555,
           (op == OP_ERASE) ? CMD_ERASE_SETUP : CMD_PROGRAM};
    end else if (op == OP_ERASE && st == 3'd5) begin
      w = {ta, CMD_SECTOR_ERASE};
    end
    return w;
  endfunction : step_word

  // index of the last write step; a plain read has none
  assign last_step = (op_ff == OP_ERASE) ? 3'd5 :
                     (op_ff == OP_PROGRAM) ? 3'd3 : 3'd0;
  // every poll passes WAIT before its compare, so the flag marks reads
  assign step_is_read = (op_ff == OP_READ) || polling_ff;

  assign {step_addr, step_data} = (op_ff == OP_READ) ? {taddr_ff, 24'h0} :
                                  step_word(op_ff, step_ff, taddr_ff,
                                            tdata_ff);

  //////////////////////////////////////////////////////////////////////
  // attribute decode and wait selection
  logic fl_hit;
  logic bk_hit;
  logic [4:0] waits_sel;
  logic tm_start;
  logic tm_busy;
  logic tm_last;
  logic cyc_issue;

  // (R2) flash select decodes its window
  efps_attr_decode #(.AW(ADDR_W)) u_fl_dec (
    .cfg(flash_select_attr_cfg_ff),
    .addr(step_addr),
    .space(tspace_ff),
    .active(1'b1),
    .hit(fl_hit)
  );
  // (R3) bank select answers X accesses only at its reset value
  efps_attr_decode #(.AW(ADDR_W)) u_bk_dec (
    .cfg(bank_select_attr_cfg_ff),
    .addr(step_addr),
    .space(tspace_ff),
    .active(1'b1),
    .hit(bk_hit)
  );

  // (R18) without priority disable only the bank select line wins
  logic bk_on;
  logic fl_on;

  assign bk_on = bk_hit;
  assign fl_on = fl_hit &&
                 (operating_mode_cfg_ff[OM_PRIO_DIS_BIT] || !bk_hit);

  // (R16) area 0 for bank hits, area 1 for flash, else default
  // (R1) reset values give twelve waits on both areas
  assign waits_sel = bk_on ? bus_wait_control_ff[BW_A0_LSB +: 5] :
                     fl_on ? bus_wait_control_ff[BW_A1_LSB +: 5] :
                     bus_wait_control_ff[BW_DEF_LSB +: 5];

  // (R19) bus-off bit holds the sequencer before any cycle
  assign cyc_issue = (state_ff == EFPS_ISSUE || state_ff == EFPS_POLL) &&
                     !tm_busy && !operating_mode_cfg_ff[OM_BUS_OFF_BIT];
  assign tm_start = cyc_issue;

  // (R22) one timer holds each cycle for the wait count
  efps_wait_timer #(.CW(5)) u_timer (
    .mclk(mclk),
    .rst_b(rst_b),
    .start(tm_start),
    .waits(waits_sel),
    .busy(tm_busy),
    .last(tm_last)
  );

  //////////////////////////////////////////////////////////////////////
  // sequencer state machine
  logic poll_match;

  // (R7) program done when read equals written word
  // (R9) erase done when upper sixteen bits all ones
  // (R10) low eight bits ignored in compares
  assign poll_match = (op_ff == OP_ERASE) ? (ext_din[23:8] == ERASED_HI) :
                      (ext_din[23:8] == tdata_ff);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      EFPS_IDLE: if (cmd_go && cmd_op != OP_NONE) nxt_state = EFPS_ISSUE;
      EFPS_ISSUE: if (cyc_issue) nxt_state = EFPS_WAIT;
      EFPS_WAIT: begin
        if (tm_last) begin
          if (op_ff == OP_READ) nxt_state = EFPS_DONE;
          else if (step_ff != last_step) nxt_state = EFPS_ISSUE;
          else if (step_is_read && poll_match) nxt_state = EFPS_DONE;
          else nxt_state = EFPS_POLL;
        end
      end
      EFPS_POLL: if (cyc_issue) nxt_state = EFPS_WAIT;
      EFPS_DONE: nxt_state = EFPS_IDLE;
      default: nxt_state = EFPS_IDLE;
    endcase
  end


  // polled cycles are marked by a flag that survives WAIT
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= EFPS_IDLE;
      op_ff <= OP_NONE;
      step_ff <= 3'd0;
      polling_ff <= 1'b0;
      done_ff <= 1'b0;
      seq_busy_ff <= 1'b0;
      rd_word_ff <= 16'h0000;
    end else begin
      state_ff <= nxt_state;
      seq_busy_ff <= (nxt_state != EFPS_IDLE);
      if (cmd_go && cmd_op != OP_NONE) begin
        op_ff <= cmd_op;
        step_ff <= 3'd0;
        polling_ff <= 1'b0;
        done_ff <= 1'b0;
      end else if (state_ff == EFPS_WAIT && tm_last) begin
        if (polling_ff || op_ff == OP_READ) begin
          rd_word_ff <= ext_din[23:8];
        end
        if (step_ff != last_step && op_ff != OP_READ) begin
          step_ff <= step_ff + 3'd1;
        end else begin
          polling_ff <= 1'b1;
        end
      end
      // set wins: done only rises here, cleared by a new command
      if (nxt_state == EFPS_DONE) begin
        done_ff <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // external port drive, registered
  logic rd_cyc;
  assign rd_cyc = polling_ff || (op_ff == OP_READ);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ext_addr <= 24'h000000;
      ext_dout <= 24'h000000;
      ext_doe <= 1'b0;
      ext_rd_b <= 1'b1;
      ext_wr_b <= 1'b1;
      flash_select_line <= 1'b1;
      bank_select_line <= 1'b0;
    end else if (cyc_issue) begin
      // (R22) address, selects and strobe held until the cycle ends
      ext_addr <= polling_ff ? taddr_ff : step_addr;
      ext_dout <= step_data;
      ext_doe <= !rd_cyc;
      ext_rd_b <= !rd_cyc;
      ext_wr_b <= rd_cyc;
      // (R12) polarity bit: 0 active low, 1 active high
      flash_select_line <= fl_on ^ !flash_select_attr_cfg_ff[AT_POL_BIT];
      bank_select_line <= bk_on ^ !bank_select_attr_cfg_ff[AT_POL_BIT];
    end else if (tm_last) begin
      ext_doe <= 1'b0;
      ext_rd_b <= 1'b1;
      ext_wr_b <= 1'b1;
      flash_select_line <= !flash_select_attr_cfg_ff[AT_POL_BIT];
      bank_select_line <= !bank_select_attr_cfg_ff[AT_POL_BIT];
    end
  end

  // busy is registered: it follows the command write by one edge
  assign seq_busy = seq_busy_ff;
endmodule : efps_sequencer

// ==== dv/efps_chk.sv ====
// assertions on the port cycles of the flash port sequencer
`timescale 1ns/10ps
module efps_chk
  import efps_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [3:0] reg_addr,
  input wire logic [23:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [23:0] ext_addr,
  input wire logic ext_doe,
  input wire logic ext_rd_b,
  input wire logic ext_wr_b,
  input wire logic flash_select_line,
  input wire logic bank_select_line,
  input wire logic seq_busy
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic [5:0] low_cnt_ff;
  logic [1:0] sp_ff;
  logic bus_off_ff;
  wire logic strobe_low = !(ext_rd_b && ext_wr_b);
  wire logic cmd_go = reg_wr && (reg_addr == OFS_CMD);
  wire logic om_wr = reg_wr && (reg_addr == OFS_OP_MODE);
  //////////////////////////////////////////////////////////////////////
  // strobe length, space of the running command, bus-off copy
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      low_cnt_ff <= 6'h00;
      sp_ff <= 2'h0;
      bus_off_ff <= 1'b0;
    end else begin
      low_cnt_ff <= strobe_low ? low_cnt_ff + 6'h01 : 6'h00;
      if (cmd_go && !seq_busy) sp_ff <= reg_wdata[3:2];
      if (om_wr) bus_off_ff <= reg_wdata[OM_BUS_OFF_BIT];
    end
  end
  //////////////////////////////////////////////////////////////////////
  // gaps between cycles keep the counter honest per cycle
  chk_strobe_len: assert property (
    $fell(strobe_low) && !$past(flash_select_line)
    |-> low_cnt_ff == 6'(FLASH_WAITS + 1))
    else $error("flash strobe length wrong");
  chk_hold_cycle: assert property (
    strobe_low && $past(strobe_low) |-> $stable(ext_addr)
    && $stable(flash_select_line) && $stable(bank_select_line))
    else $error("address or select moved inside a cycle");
  chk_flash_window: assert property (
    strobe_low |-> flash_select_line
    == !(ext_addr >= FL_BASE && ext_addr <= 24'h11FFFF))
    else $error("flash select does not follow window");
  chk_bank_space: assert property (
    strobe_low && !flash_select_line
    |-> bank_select_line == (sp_ff == SP_X))
    else $error("bank select does not follow space");
  chk_write_drive: assert property (
    !ext_wr_b |-> ext_rd_b && ext_doe)
    else $error("write strobe without data drive");
  chk_read_float: assert property (
    !ext_rd_b |-> !ext_doe)
    else $error("data driven during read");
  chk_cmd_start: assert property (
    cmd_go && reg_wdata[1:0] != OP_NONE && !seq_busy |-> ##[1:3] seq_busy)
    else $error("command did not start");
  chk_bus_off: assert property (
    bus_off_ff && !strobe_low |=> !strobe_low)
    else $error("cycle started with bus off");
endmodule : efps_chk

bind efps_sequencer efps_chk u_chk (.mclk(mclk), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .ext_addr(ext_addr), .ext_doe(ext_doe), .ext_rd_b(ext_rd_b),
  .ext_wr_b(ext_wr_b), .flash_select_line(flash_select_line),
  .bank_select_line(bank_select_line), .seq_busy(seq_busy));

// ==== dv/efps_flash_model.sv ====
// behavioural parallel flash on the far side of the port
`timescale 1ns/10ps
module efps_flash_model (
  input wire logic mclk,
  input wire logic [23:0] ext_addr,
  input wire logic [23:0] ext_dout,
  input wire logic ext_rd_b,
  input wire logic ext_wr_b,
  input wire logic flash_select_line,
  input wire logic bank_select_line,
  output logic [23:0] ext_din
);
  logic [15:0] mem [logic [17:0]];
  logic [23:0] log_a [$];
  logic [23:0] log_d [$];
  int n_rd, step, busy;
  logic pgm, wr_q, rd_q;
  // word index: bank line picks the half
  wire logic [17:0] idx = {bank_select_line, ext_addr[16:0]};
  wire logic wr_on = !ext_wr_b && !flash_select_line;
  wire logic rd_on = !ext_rd_b && !flash_select_line;
  wire logic [15:0] dh = ext_dout[23:8];
  wire logic [15:0] a16 = ext_addr[15:0];
  function automatic logic [15:0] peek(input logic [17:0] i);
    return mem.exists(i) ? mem[i] : 16'hFFFF;
  endfunction : peek
  task automatic clear;
    log_a.delete();
    log_d.delete();
    n_rd = 0;
  endtask : clear
  initial begin
    ext_din = 24'h000000;
    {n_rd, step, busy} = '0;
    {pgm, wr_q, rd_q} = '0;
  end
  //////////////////////////////////////////////////////////////////////
  // busy reads differ; idle bus toggles, no stale value
  always @(posedge mclk) begin
    wr_q <= wr_on;
    rd_q <= rd_on;
    if (rd_on) ext_din <= {busy > 0 ? ~peek(idx) : peek(idx), 8'h00};
    else ext_din <= ~ext_din;
    if (!rd_on && rd_q) begin
      n_rd++;
      if (busy > 0) busy--;
    end
    if (wr_on && !wr_q) begin
      log_a.push_back(ext_addr);
      log_d.push_back(ext_dout);
      if (pgm) begin
        mem[idx] = peek(idx) & dh;
        pgm = 0;
        busy = 3;
      end
      else if (step == 0 && a16 == 16'h5555 && dh == 16'hAAAA) step = 1;
      else if ((step == 1 || step == 4) && a16 == 16'h2AAA && dh == 16'h5555)
        step++;
      else if (step == 2 && a16 == 16'h5555 && dh == 16'hA0A0) begin
        pgm = 1;
        step = 0;
      end
      else if (step == 2 && a16 == 16'h5555 && dh == 16'h8080) step = 3;
      else if (step == 3 && a16 == 16'h5555 && dh == 16'hAAAA) step = 4;
      else if (step == 5 && dh == 16'h3030) begin
        foreach (mem[k]) if (k[17:15] == idx[17:15]) mem[k] = 16'hFFFF;
        busy = 3;
        step = 0;
      end
      else step = 0;
    end
  end
endmodule : efps_flash_model

// ==== dv/testbench.sv ====
// self-checking bench for the external flash port sequencer
`timescale 1ns/10ps
module testbench;
  import efps_pkg::*;
  logic mclk, rst_b, reg_wr, reg_rd, ext_doe, ext_rd_b, ext_wr_b;
  logic flash_select_line, bank_select_line, seq_busy;
  logic [3:0] reg_addr;
  logic [23:0] reg_wdata, reg_rdata, ext_addr, ext_dout, ext_din;
  int err_total, checks;
  efps_sequencer DUT (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ext_addr(ext_addr), .ext_dout(ext_dout),
    .ext_doe(ext_doe), .ext_din(ext_din), .ext_rd_b(ext_rd_b),
    .ext_wr_b(ext_wr_b), .flash_select_line(flash_select_line),
    .bank_select_line(bank_select_line), .seq_busy(seq_busy));
  efps_flash_model flash (.mclk(mclk), .ext_addr(ext_addr),
    .ext_dout(ext_dout), .ext_rd_b(ext_rd_b), .ext_wr_b(ext_wr_b),
    .flash_select_line(flash_select_line),
    .bank_select_line(bank_select_line), .ext_din(ext_din));
  //////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    if (err_total == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  task automatic cmp24(input string nm, input logic [23:0] e, g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp24
  // register port: one-cycle strobes, read data in the next cycle
  task automatic wr(input logic [3:0] a, input logic [23:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [23:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // polls status; a hang ends the run
  task automatic wait_idle;
    logic [23:0] v;
    for (int i = 0; i < 400; i++) begin
      rd(OFS_STATUS, v);
      if (v[0] === 1'b0) return;
    end
    cmp24("idle wait", 24'h0, 24'h1);
    print_verdict();
  endtask : wait_idle
  task automatic cmd(input logic [1:0] op, sp, input logic [23:0] a,
                     input logic [15:0] d);
    wr(OFS_TADDR, a);
    wr(OFS_TDATA, {d, 8'h00});
    wr(OFS_CMD, {20'h0, sp, op});
    wait_idle();
  endtask : cmd
  task automatic rdw(input logic [1:0] sp, input logic [23:0] a,
                     input logic [15:0] e);
    logic [23:0] v;
    cmd(OP_READ, sp, a, 16'h0000);
    rd(OFS_RDATA, v);
    cmp24("flash word", {e, 8'h00}, {v[23:8], 8'h00});
  endtask : rdw
  task automatic chk_seq(input int n, input logic [23:0] ea [6], ed [6]);
    cmp24("write count", 24'(n), 24'(flash.log_a.size()));
    for (int i = 0; i < n; i++) begin
      cmp24("write addr", ea[i], flash.log_a[i]);
      cmp24("write data", ed[i], {flash.log_d[i][23:8], 8'h00});
    end
  endtask : chk_seq
  //////////////////////////////////////////////////////////////////////
  // reset values and masks
  task automatic t_regs;
    logic [23:0] v;
    logic [23:0] ex [7] = '{24'h100731, 24'h100715, 24'h000000,
      24'h000000, {8'h00, 3'h0, 3'h0, 5'd12, 5'd12}, 24'h004000, 24'h0};
    logic [3:0] ad [7] = '{OFS_FLASH_SEL, OFS_BANK_SEL, OFS_SPARE_TWO,
      OFS_SPARE_THREE, OFS_BUS_WAIT, OFS_OP_MODE, 4'hF};
    for (int i = 0; i < 7; i++) begin
      rd(ad[i], v);
      cmp24("reset value", ex[i], v);
    end
    wr(OFS_SPARE_TWO, 24'hFFFFFF);
    rd(OFS_SPARE_TWO, v);
    cmp24("spare write", 24'h000000, v);
    wr(OFS_FLASH_SEL, 24'hFFFFFF);
    rd(OFS_FLASH_SEL, v);
    cmp24("attr mask", 24'hFFFF3F, v);
    wr(OFS_BUS_WAIT, 24'hFFFFFF);
    rd(OFS_BUS_WAIT, v);
    cmp24("wait mask", 24'h00FFFF, v);
    wr(OFS_OP_MODE, 24'hFFFFFF);
    rd(OFS_OP_MODE, v);
    cmp24("mode mask", 24'h004010, v);
    wr(OFS_BUS_WAIT, 24'h00018C);
    wr(OFS_OP_MODE, 24'h004000);
    wr(OFS_FLASH_SEL, 24'h100731);
  endtask : t_regs
  task automatic t_bus_off;
    logic [23:0] v;
    wr(OFS_OP_MODE, 24'h004010);
    wr(OFS_TADDR, 24'h100010);
    wr(OFS_CMD, {20'h0, SP_Y, OP_READ});
    repeat (40) @(posedge mclk);
    cmp24("stalled strobe", 24'h1, {23'h0, ext_rd_b});
    wr(OFS_OP_MODE, 24'h004000);
    wait_idle();
    rd(OFS_RDATA, v);
    cmp24("erased read", 24'hFFFF00, {v[23:8], 8'h00});
  endtask : t_bus_off
  task automatic t_program;
    logic [23:0] v;
    flash.clear();
    cmd(OP_PROGRAM, SP_X, 24'h101234, 16'hA5C3);
    chk_seq(4, '{24'h105555, 24'h102AAA, 24'h105555, 24'h101234, 0, 0},
      '{24'hAAAA00, 24'h555500, 24'hA0A000, 24'hA5C300, 0, 0});
    cmp24("program polls", 24'd4, 24'(flash.n_rd));
    rd(OFS_STATUS, v);
    cmp24("done flag", 24'h2, {22'h0, v[1:0]});
    cmd(OP_PROGRAM, SP_Y, 24'h101234, 16'h3C5A);
    cmd(OP_PROGRAM, SP_X, 24'h109000, 16'h1234);
    rdw(SP_X, 24'h101234, 16'hA5C3);
    rdw(SP_Y, 24'h101234, 16'h3C5A);
  endtask : t_program
  task automatic t_erase;
    flash.clear();
    cmd(OP_ERASE, SP_X, 24'h101234, 16'h0000);
    chk_seq(6, '{24'h105555, 24'h102AAA, 24'h105555, 24'h105555,
      24'h102AAA, 24'h101234}, '{24'hAAAA00, 24'h555500, 24'h808000,
      24'hAAAA00, 24'h555500, 24'h303000});
    cmp24("erase polls", 24'd4, 24'(flash.n_rd));
    rdw(SP_X, 24'h101234, 16'hFFFF);
    rdw(SP_X, 24'h109000, 16'h1234);
    rdw(SP_Y, 24'h101234, 16'h3C5A);
  endtask : t_erase
  //////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    {rst_b, reg_wr, reg_rd} = 3'b000;
    reg_addr = 4'h0;
    reg_wdata = 24'h000000;
    err_total = 0;
    checks = 0;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    t_regs();
    t_bus_off();
    t_program();
    t_erase();
    print_verdict();
  end
endmodule : testbench
